// ---- pkg/irm_regs.svh ----
// offsets, field positions, reset values, op codes and timing counts
// assumes: included by its bare name from the core, the checker and the bench
`ifndef IRM_REGS_SVH
`define IRM_REGS_SVH

// apb register byte offsets
`define IRM_OFS_MODE 8'h00
`define IRM_OFS_XR1 8'h04
`define IRM_OFS_XR2 8'h08
`define IRM_OFS_XR3 8'h0C
`define IRM_OFS_STATUS 8'h10

// mode register field and status fields
`define IRM_MODE_BIT 0
`define IRM_STAT_READY_BIT 0
`define IRM_STAT_HIST_LSB 4

// reset values
`define IRM_MODE_RST 1'h0
`define IRM_XR_RST 12'h000

// instruction word fields, word[35] is sign position, word[0] bit 35
`define IRM_F_OP_MSB 35
`define IRM_F_OP_LSB 30
`define IRM_F_ADDR_MSB 29
`define IRM_F_ADDR_LSB 18
`define IRM_F_IND 17
`define IRM_F_TAG_MSB 14
`define IRM_F_TAG_LSB 12
`define IRM_F_DEC_MSB 11
`define IRM_F_DEC_LSB 0
`define IRM_ACC_FLD_MSB 29
`define IRM_ACC_FLD_LSB 18

// tag codes
`define IRM_TAG_NONE 3'h0
`define IRM_TAG_R1 3'h1
`define IRM_TAG_R2 3'h2
`define IRM_TAG_R3 3'h4

// six-bit op codes (sign included), values arbitrary
`define IRM_OP_SENSE 6'h00
`define IRM_OP_TIX 6'h21
`define IRM_OP_TNX 6'h22
`define IRM_OP_LXC1 6'h23
`define IRM_OP_LXC2 6'h24
`define IRM_OP_LXC4 6'h25
`define IRM_OP_HTR1 6'h01
`define IRM_OP_HTR2 6'h02
`define IRM_OP_LDA 6'h03
`define IRM_OP_MPY 6'h10
`define IRM_OP_DIV 6'h11
`define IRM_OP_FMP 6'h12
`define IRM_OP_FDV 6'h13

// sense-type left half words (whole 18 bits), values arbitrary
`define IRM_HW_LDX 18'h0_0101
`define IRM_HW_ACX 18'h0_0102
`define IRM_HW_CPX 18'h0_0103
`define IRM_HW_EIM 18'h0_0104

// timing
`define IRM_CLK_PERIOD_NS 40
`define IRM_BASIC_CYCLE_US 12
`define IRM_BASIC_CLKS \
  ((`IRM_BASIC_CYCLE_US * 1000 + `IRM_CLK_PERIOD_NS - 1) / `IRM_CLK_PERIOD_NS)
`define IRM_SLOW_CYCLES 4
`define IRM_FAST_CYCLES 2
`define IRM_HIST_DEPTH 3'h6

`endif

// ---- pkg/irm_pkg.sv ----
// types for the index register address modifier
// assumes: constants come from irm_regs.svh
package irm_pkg;

  typedef enum logic [0:0] {
    IRM_IDLE = 1'b0,
    IRM_EXEC = 1'b1
  } irm_state_t;

  typedef struct packed {
    irm_state_t st;
    logic mode;
    logic [2:0][11:0] xr;
    logic [10:0] cnt;
    logic [2:0] hist;
    logic ready;
    logic ir_valid;
    logic [5:0] ir_op;
    logic [11:0] ir_addr;
    logic acc_we;
    logic [35:0] acc_value;
    logic xfer;
    logic [11:0] xfer_addr;
    logic fetch_full;
    logic done;
    logic p_xr_we;
    logic [1:0] p_xr_idx;
    logic [11:0] p_xr_val;
    logic p_acc;
    logic [35:0] p_acc_value;
    logic p_xfer;
    logic [11:0] p_xfer_addr;
    logic p_mode;
    logic p_full;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } irm_core_t;

endpackage

// ---- verilog/irm_core.sv ----
// index register address modifier: indexing mode, three index registers,
// address modification and the index-specific operations, apb registers.
// assumes: fetch and datapath run on clk; fetch holds instr_valid until
// instr_ready; in normal mode the half word sits in instr_word[35:18].
//
// Overview of operation
// - mode clear: half-word instructions; mode set: full-word indexed ones.
// - indexed word: 6-bit op with sign, 12-bit address; indicator, tag, decrement.
// - indicator field 1 clears mode after execution; 0 leaves it.
// - three 12-bit index registers chosen by the tag field.
// - tag 0 none, 1 first, 2 second, 4 third register.
// - modifiable instructions also run in normal mode, unmodified.
// - index-specific op in normal mode sets mode, runs as indexed.
// - register-accessing ops use tag only to pick the register.
// - halt-transfer, locate-drum, plain sense ops never get modified addresses.
// - sign, op and, for tag 0, raw address go to instruction register.
// - selected tag: address minus register, modulo 4096, to instruction register.
// - indexed instruction adds no cycles over the resulting normal one.
// - load index copies decrement bits 24-35 into tagged register.
// - accumulator-to-index copies accumulator bits 6-17 into tagged register.
// - compare index writes register minus decrement to accumulator 6-17, rest zero.
// - transfer on index: if register exceeds decrement, reduce and jump.
// - transfer on no index jumps when reduction would be zero or negative.
// - five index-specific ops keep indexing mode until indicator 1.
// - enter indexing mode sets mode, fetches next higher full word.
// - load complement in normal mode stores negated address in named register.
// - indexed load complement reduces address first, then stores its negation.
// - index operations take 4 basic cycles, 2 after recent multiply/divide.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "irm_regs.svh"

module irm_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction fetch side
  input wire logic instr_valid,
  input wire logic [35:0] instr_word,
  output logic instr_ready,
  output logic index_mode,
  output logic fetch_next_full,
  // instruction register toward normal execution
  output logic ir_valid,
  output logic [5:0] ir_op,
  output logic [11:0] ir_addr,
  // accumulator
  input wire logic [11:0] acc_field,
  output logic acc_we,
  output logic [35:0] acc_value,
  // control transfer and completion
  output logic xfer,
  output logic [11:0] xfer_addr,
  output logic exec_done,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata
);

  // counts load one short: the zero state is the last cycle of the op
  localparam logic [10:0] SLOW_CNT =
    11'(`IRM_SLOW_CYCLES * `IRM_BASIC_CLKS - 1);
  localparam logic [10:0] FAST_CNT =
    11'(`IRM_FAST_CYCLES * `IRM_BASIC_CLKS - 1);

  // whole block state, registered in one place
  irm_pkg::irm_core_t s;
  irm_pkg::irm_core_t next_s;

  // instruction fields
  logic [5:0] f_op;
  logic [17:0] f_half;
  logic [11:0] f_addr;
  logic f_ind;
  logic [2:0] f_tag;
  logic [11:0] f_dec;
  // decode
  logic is_sense;
  logic is_ldx;
  logic is_acx;
  logic is_cpx;
  logic is_tix;
  logic is_tnx;
  logic is_eim;
  logic is_lxc;
  logic is_muldiv;
  logic idx_op;
  logic nonmod;
  logic indexed;
  logic tag_hit;
  logic [1:0] tag_idx;
  logic [1:0] lxc_idx;
  logic [11:0] xr_sel;
  logic [11:0] eff_addr;
  logic [11:0] xr_less_dec;
  logic xr_gt_dec;
  logic take;
  logic fast;
  // apb decode
  logic apb_setup;
  logic apb_wr;
  logic apb_hit;

  // in normal mode only the left half word is looked at, except by the five index-specific ops
  // indexed word fields
  assign f_op = instr_word[`IRM_F_OP_MSB:`IRM_F_OP_LSB];
  assign f_half = instr_word[35:18];
  assign f_addr = instr_word[`IRM_F_ADDR_MSB:`IRM_F_ADDR_LSB];
  assign f_ind = instr_word[`IRM_F_IND];
  assign f_tag = instr_word[`IRM_F_TAG_MSB:`IRM_F_TAG_LSB];
  assign f_dec = instr_word[`IRM_F_DEC_MSB:`IRM_F_DEC_LSB];

  assign is_sense = (f_op == `IRM_OP_SENSE);
  assign is_ldx = (f_half == `IRM_HW_LDX);
  assign is_acx = (f_half == `IRM_HW_ACX);
  assign is_cpx = (f_half == `IRM_HW_CPX);
  assign is_eim = (f_half == `IRM_HW_EIM);
  assign is_tix = (f_op == `IRM_OP_TIX);
  assign is_tnx = (f_op == `IRM_OP_TNX);
  // load-complement ops may also be modified
  assign is_lxc = (f_op == `IRM_OP_LXC1) || (f_op == `IRM_OP_LXC2) ||
                  (f_op == `IRM_OP_LXC4);
  // multiply and divide open the fast window
  assign is_muldiv = (f_op == `IRM_OP_MPY) || (f_op == `IRM_OP_DIV) ||
                     (f_op == `IRM_OP_FMP) || (f_op == `IRM_OP_FDV);
  // the five ops that always run indexed
  assign idx_op = is_ldx || is_acx || is_cpx || is_tix || is_tnx;

  assign indexed = s.mode || idx_op;

  assign nonmod = idx_op || is_sense || (f_op == `IRM_OP_HTR1) ||
                  (f_op == `IRM_OP_HTR2) || (f_op == `IRM_OP_LDA);

  // illegal tags select nothing, like tag zero
  // tag decode
  always_comb begin
    tag_hit = indexed;
    tag_idx = 2'h0;
    unique case (f_tag)
      `IRM_TAG_R1: tag_idx = 2'h0;
      `IRM_TAG_R2: tag_idx = 2'h1;
      `IRM_TAG_R3: tag_idx = 2'h2;
      default: tag_hit = 1'b0;
    endcase
  end

  // load-complement destination comes from the op code, not the tag
  always_comb begin
    unique case (f_op)
      `IRM_OP_LXC2: lxc_idx = 2'h1;
      `IRM_OP_LXC4: lxc_idx = 2'h2;
      default: lxc_idx = 2'h0;
    endcase
  end

  assign xr_sel = tag_hit ? s.xr[tag_idx] : 12'h000;

  // read view of the index registers, one bus word each
  logic [2:0][31:0] xr_view;
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_xr_view
    assign xr_view[gi] = {20'h0_0000, s.xr[gi]};
  end

  // negative differences wrap to their 12-bit complement
  // subtract modulo 4096
  assign eff_addr = (tag_hit && !nonmod) ? (f_addr - xr_sel) : f_addr;

  // shared by compare and both transfer ops
  assign xr_less_dec = xr_sel - f_dec;
  assign xr_gt_dec = (xr_sel > f_dec);

  assign take = instr_valid && s.ready;
  // a multiply or divide among the last six taken instructions
  assign fast = (s.hist != 3'h0);

  // the bus answers one cycle after setup, no wait states
  assign apb_setup = psel && !penable;
  // writes land at the access edge, while pready stands high
  assign apb_wr = psel && penable && s.pready && pwrite && apb_hit;
  assign apb_hit = (paddr == `IRM_OFS_MODE) || (paddr == `IRM_OFS_XR1) ||
                   (paddr == `IRM_OFS_XR2) || (paddr == `IRM_OFS_XR3) ||
                   (paddr == `IRM_OFS_STATUS);

  // one write strobe per index register at the end of an index op
  logic end_of_op;
  logic [2:0] xr_end_we;
  assign end_of_op = (s.st == irm_pkg::IRM_EXEC) && (s.cnt == 11'h000);
  for (gi = 0; gi < 3; gi++) begin : g_xr_we
    assign xr_end_we[gi] = end_of_op && s.p_xr_we &&
                           (s.p_xr_idx == 2'(gi));
  end

  always_comb begin
    next_s = s;
    // pulses last one cycle
    next_s.ir_valid = 1'b0;
    next_s.acc_we = 1'b0;
    next_s.xfer = 1'b0;
    next_s.fetch_full = 1'b0;
    next_s.done = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;

    // apb: answer in the cycle after setup
    if (apb_setup) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !apb_hit;
      // read data is latched at setup and held until the next setup
      unique case (paddr)
        `IRM_OFS_MODE: next_s.prdata = {31'h0000_0000, s.mode};
        `IRM_OFS_XR1: next_s.prdata = xr_view[0];
        `IRM_OFS_XR2: next_s.prdata = xr_view[1];
        `IRM_OFS_XR3: next_s.prdata = xr_view[2];
        `IRM_OFS_STATUS: next_s.prdata = {25'h000_0000, s.hist,
                                          3'h0, s.ready};
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_wr) begin
      unique case (paddr)
        `IRM_OFS_MODE: next_s.mode = pwdata[`IRM_MODE_BIT];
        `IRM_OFS_XR1: next_s.xr[0] = pwdata[11:0];
        `IRM_OFS_XR2: next_s.xr[1] = pwdata[11:0];
        `IRM_OFS_XR3: next_s.xr[2] = pwdata[11:0];
        default: next_s.prdata = s.prdata;
      endcase
    end

    unique case (s.st)
      irm_pkg::IRM_IDLE: begin
        if (take) begin
          // counts taken instructions, not cycles
          // recent multiply window
          if (is_muldiv) begin
            next_s.hist = `IRM_HIST_DEPTH;
          end else if (fast) begin
            next_s.hist = s.hist - 3'h1;
          end
          // results of an index op wait here until its count runs out
          next_s.p_xr_we = 1'b0;
          next_s.p_xr_idx = tag_idx;
          next_s.p_xr_val = 12'h000;
          next_s.p_acc = 1'b0;
          next_s.p_acc_value = 36'h0_0000_0000;
          next_s.p_xfer = 1'b0;
          next_s.p_xfer_addr = f_addr;
          next_s.p_full = is_eim;
          next_s.p_mode = s.mode || idx_op || is_eim;
          // when indexed, an indicator of 1 wins over the set above
          // indicator clears
          if (indexed && f_ind) begin
            next_s.p_mode = 1'b0;
          end
          // index operations run in the counting state
          if (idx_op || is_lxc || is_eim) begin
            next_s.st = irm_pkg::IRM_EXEC;
            next_s.ready = 1'b0;
            next_s.cnt = fast ? FAST_CNT : SLOW_CNT;
            if (is_ldx) begin
              next_s.p_xr_we = tag_hit;
              next_s.p_xr_val = f_dec;
            end
            if (is_acx) begin
              next_s.p_xr_we = tag_hit;
              next_s.p_xr_val = acc_field;
            end
            if (is_cpx) begin
              next_s.p_acc = 1'b1;
              next_s.p_acc_value = {6'h00, xr_less_dec, 18'h0_0000};
            end
            if (is_tix || is_tnx) begin
              next_s.p_xr_we = xr_gt_dec;
              next_s.p_xr_val = xr_less_dec;
              next_s.p_xfer = is_tix ? xr_gt_dec : 1'b0;
            end
            if (is_tnx) begin
              next_s.p_xfer = !xr_gt_dec;
            end
            if (is_lxc) begin
              next_s.p_xr_we = 1'b1;
              next_s.p_xr_idx = lxc_idx;
              next_s.p_xr_val = 12'h000 - eff_addr;
            end
          end else begin
            next_s.ir_valid = 1'b1;
            next_s.ir_op = f_op;
            next_s.ir_addr = eff_addr;
            // plain ops change mode from the next fetch
            next_s.mode = next_s.p_mode;
          end
        end
      end
      irm_pkg::IRM_EXEC: begin
        // results are released in the last counted cycle
        if (s.cnt == 11'h000) begin
          next_s.st = irm_pkg::IRM_IDLE;
          next_s.ready = 1'b1;
          next_s.done = 1'b1;
          for (int i = 0; i < 3; i++) begin
            if (xr_end_we[i]) begin
              next_s.xr[i] = s.p_xr_val;
            end
          end
          next_s.acc_we = s.p_acc;
          next_s.acc_value = s.p_acc_value;
          next_s.xfer = s.p_xfer;
          next_s.xfer_addr = s.p_xfer_addr;
          next_s.fetch_full = s.p_full;
          // the op's mode overrides a bus write in the same edge
          // mode at completion
          next_s.mode = s.p_mode;
        end else begin
          next_s.cnt = s.cnt - 11'h001;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // idle and ready, normal mode, index registers cleared
      s <= '0;
      s.st <= irm_pkg::IRM_IDLE;
      s.mode <= `IRM_MODE_RST;
      s.xr <= {3{`IRM_XR_RST}};
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // every output straight from a state flop
  assign instr_ready = s.ready;
  assign index_mode = s.mode;
  assign fetch_next_full = s.fetch_full;
  assign ir_valid = s.ir_valid;
  assign ir_op = s.ir_op;
  assign ir_addr = s.ir_addr;
  assign acc_we = s.acc_we;
  assign acc_value = s.acc_value;
  assign xfer = s.xfer;
  assign xfer_addr = s.xfer_addr;
  assign exec_done = s.done;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign prdata = s.prdata;

endmodule

// ---- test/irm_core_assertions.sv ----
// port checker for irm_core
// assumes: bound to irm_core, codes from irm_regs.svh
`timescale 1ns/10ps
`include "irm_regs.svh"
module irm_core_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction side
  input wire logic instr_valid,
  input wire logic [35:0] instr_word,
  input wire logic instr_ready,
  input wire logic index_mode,
  input wire logic fetch_next_full,
  input wire logic ir_valid,
  input wire logic [11:0] ir_addr,
  // results
  input wire logic acc_we,
  input wire logic [35:0] acc_value,
  input wire logic exec_done
);
  wire [5:0] op = instr_word[35:30];
  wire [17:0] hw = instr_word[35:18];
  wire [11:0] adr = instr_word[29:18];
  wire take = instr_valid && instr_ready;
  wire five = hw == `IRM_HW_LDX || hw == `IRM_HW_ACX ||
    hw == `IRM_HW_CPX || op == `IRM_OP_TIX || op == `IRM_OP_TNX;
  wire ix = five || hw == `IRM_HW_EIM || op == `IRM_OP_LXC1 ||
    op == `IRM_OP_LXC2 || op == `IRM_OP_LXC4;
  wire keep = op == `IRM_OP_HTR1 || op == `IRM_OP_HTR2 ||
    op == `IRM_OP_LDA;
  wire plain = !ix && !keep && op != `IRM_OP_SENSE;
  logic [10:0] cnt;
  logic sets;
  // cycles since the last take, and whether that op leaves mode set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 11'h000;
      sets <= 1'b0;
    end else if (take) begin
      cnt <= 11'h000;
      sets <= (five && !instr_word[17]) || hw == `IRM_HW_EIM;
    end else if (cnt != 11'h7FF) begin
      cnt <= cnt + 11'h001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ixtake;
    take && ix;
  endsequence
  sequence s_stall;
    (!instr_ready && !ir_valid) [*8];
  endsequence
  property p_tag0;
    take && plain && index_mode && instr_word[14:12] == 3'h0
      |=> ir_valid && ir_addr == $past(adr);
  endproperty
  a_tag0: assert property (p_tag0) else $error("tag zero address moved");
  property p_norm;
    take && plain && !index_mode |=> ir_valid && ir_addr == $past(adr);
  endproperty
  a_norm: assert property (p_norm) else $error("normal address moved");
  property p_keep;
    take && keep |=> ir_valid && ir_addr == $past(adr);
  endproperty
  a_keep: assert property (p_keep) else $error("fixed op address moved");
  property p_clr;
    take && plain && index_mode && instr_word[17] |=> !index_mode;
  endproperty
  a_clr: assert property (p_clr) else $error("mode not cleared");
  property p_time;
    exec_done |-> cnt == 11'h4B0 || cnt == 11'h258;
  endproperty
  a_time: assert property (p_time) else $error("index op length wrong");
  property p_busy;
    s_ixtake |=> s_stall;
  endproperty
  a_busy: assert property (p_busy) else $error("index op reached ir");
  property p_mode;
    exec_done && sets |-> index_mode;
  endproperty
  a_mode: assert property (p_mode) else $error("mode not set");
  property p_acc;
    acc_we |-> acc_value[35:30] == 6'h00 && acc_value[17:0] == 18'h0_0000;
  endproperty
  a_acc: assert property (p_acc) else $error("acc bits not clear");
  property p_eim;
    fetch_next_full |-> index_mode && exec_done;
  endproperty
  a_eim: assert property (p_eim) else $error("full fetch without mode");
endmodule

bind irm_core irm_core_assertions u_chk (
  .clk(clk), .rst(rst), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready),
  .index_mode(index_mode), .fetch_next_full(fetch_next_full),
  .ir_valid(ir_valid), .ir_addr(ir_addr), .acc_we(acc_we),
  .acc_value(acc_value), .exec_done(exec_done)
);

// ---- test/irm_fetch_model.sv ----
// instruction fetch model facing irm_core
// assumes: bench raises offer with a word, held until taken
`timescale 1ns/10ps
module irm_fetch_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench request
  input wire logic offer,
  input wire logic [35:0] offer_word,
  // toward the core
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [35:0] instr_word
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_valid <= 1'b0;
      instr_word <= 36'h0_0000_0000;
    end else if (instr_valid && instr_ready) begin
      // word released: show its inverse, not a stale copy
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end else if (offer && !instr_valid) begin
      instr_valid <= 1'b1;
      instr_word <= offer_word;
    end
  end
endmodule

// ---- test/tb_index_register_address_modifier.sv ----
// bench for irm_core: apb register access and instruction stream
// assumes: fetch model in irm_fetch_model, checker bound by itself
`timescale 1ns/10ps
`include "irm_regs.svh"
module tb_index_register_address_modifier;
  logic clk, rst, psel, penable, pwrite, offer, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [35:0] offer_word, instr_word, acc_value;
  logic [11:0] acc_field, ir_addr, xfer_addr;
  logic [5:0] ir_op;
  logic instr_valid, instr_ready, index_mode, fetch_next_full, ir_valid;
  logic acc_we, xfer, exec_done, pready, pslverr;
  int num_errors, cmp_count;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  irm_core DUT (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready),
    .index_mode(index_mode), .fetch_next_full(fetch_next_full),
    .ir_valid(ir_valid), .ir_op(ir_op), .ir_addr(ir_addr),
    .acc_field(acc_field), .acc_we(acc_we), .acc_value(acc_value),
    .xfer(xfer), .xfer_addr(xfer_addr), .exec_done(exec_done),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
  irm_fetch_model u_fetch (.clk(clk), .rst(rst), .offer(offer),
    .offer_word(offer_word), .instr_ready(instr_ready),
    .instr_valid(instr_valid), .instr_word(instr_word));

  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    final_report();
  endtask

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    cmp({3'h0, err, rd}, {3'h0, ee, e});
  endtask

  function automatic logic [35:0] iw(input logic [17:0] h,
    input logic ind, input logic [2:0] t, input logic [11:0] d);
    return {h, ind, 2'b00, t, d};
  endfunction

  task automatic issue(input logic [35:0] w);
    @(posedge clk);
    offer <= 1'b1;
    offer_word <= w;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if ((instr_valid & instr_ready) === 1'b1) begin
        @(posedge clk);
        offer <= 1'b0;
        @(negedge clk);
        return;
      end
    end
    hang();
  endtask

  task automatic done_in(input int n);
    int k;
    k = 0;
    while (exec_done !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 2000) begin
      hang();
    end
    cmp(36'(k), 36'(n));
  endtask

  task automatic irc(input logic [5:0] o, input logic [11:0] a);
    cmp({17'h0, ir_valid, ir_op, ir_addr}, {17'h0, 1'b1, o, a});
  endtask

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, offer} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    offer_word = 36'h0_0000_0000;
    acc_field = 12'h2AA;
    num_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(`IRM_OFS_MODE, 32'h0000_0000, 1'b0);
    rdc(`IRM_OFS_XR1, 32'h0000_0000, 1'b0);
    rdc(8'h40, 32'h0000_0000, 1'b1);
    apb(1'b1, `IRM_OFS_XR1, 32'h0000_0005);
    apb(1'b1, `IRM_OFS_MODE, 32'h0000_0001);
    $display("test registers done");
    issue(iw({6'h30, 12'h003}, 1'b1, `IRM_TAG_R1, 12'h000));
    irc(6'h30, 12'hFFE);
    cmp({35'h0, index_mode}, 36'h0);
    issue(iw({6'h31, 12'h777}, 1'b0, `IRM_TAG_R1, 12'h000));
    irc(6'h31, 12'h777);
    $display("test modify done");
    issue(iw(`IRM_HW_LDX, 1'b0, `IRM_TAG_R2, 12'h123));
    done_in(1200);
    cmp({35'h0, index_mode}, 36'h1);
    rdc(`IRM_OFS_XR2, 32'h0000_0123, 1'b0);
    issue(iw({`IRM_OP_HTR1, 12'h040}, 1'b0, `IRM_TAG_R2, 12'h000));
    irc(`IRM_OP_HTR1, 12'h040);
    issue(iw({`IRM_OP_TIX, 12'h055}, 1'b0, `IRM_TAG_R2, 12'h100));
    done_in(1200);
    cmp({23'h0, xfer, xfer_addr}, {23'h0, 1'b1, 12'h055});
    rdc(`IRM_OFS_XR2, 32'h0000_0023, 1'b0);
    issue(iw(`IRM_HW_CPX, 1'b0, `IRM_TAG_R2, 12'h030));
    done_in(1200);
    cmp(acc_value, {6'h00, 12'hFF3, 18'h0_0000});
    cmp({35'h0, acc_we}, 36'h1);
    issue(iw({`IRM_OP_TNX, 12'h066}, 1'b0, `IRM_TAG_R2, 12'h023));
    done_in(1200);
    cmp({23'h0, xfer, xfer_addr}, {23'h0, 1'b1, 12'h066});
    rdc(`IRM_OFS_XR2, 32'h0000_0023, 1'b0);
    cmp({35'h0, index_mode}, 36'h1);
    $display("test index ops done");
    issue(iw({`IRM_OP_MPY, 12'h010}, 1'b1, `IRM_TAG_NONE, 12'h000));
    cmp({35'h0, index_mode}, 36'h0);
    issue(iw({`IRM_OP_LXC1, 12'h005}, 1'b0, `IRM_TAG_R2, 12'h000));
    done_in(600);
    rdc(`IRM_OFS_XR1, 32'h0000_0FFB, 1'b0);
    issue(iw(`IRM_HW_ACX, 1'b1, `IRM_TAG_R3, 12'h000));
    done_in(600);
    rdc(`IRM_OFS_XR3, 32'h0000_02AA, 1'b0);
    cmp({35'h0, index_mode}, 36'h0);
    issue(iw(`IRM_HW_EIM, 1'b0, `IRM_TAG_NONE, 12'h000));
    done_in(600);
    cmp({34'h0, fetch_next_full, index_mode}, 36'h3);
    $display("test fast timing done");
    issue(iw({6'h32, 12'h0AB}, 1'b0, `IRM_TAG_NONE, 12'h000));
    irc(6'h32, 12'h0AB);
    issue(iw({`IRM_OP_LXC1, 12'h010}, 1'b0, `IRM_TAG_R1, 12'h000));
    done_in(600);
    rdc(`IRM_OFS_XR1, 32'h0000_0FEB, 1'b0);
    issue(iw({`IRM_OP_TIX, 12'h077}, 1'b0, `IRM_TAG_R1, 12'hFFF));
    done_in(600);
    cmp({23'h0, xfer, xfer_addr}, {23'h0, 1'b0, 12'h077});
    rdc(`IRM_OFS_XR1, 32'h0000_0FEB, 1'b0);
    $display("test indexed tag done");
    final_report();
  end
endmodule
